// ==== core/ecpwm_core.sv ====
// Purpose: Mode decode, capture, compare and enhanced PWM output logic
// Assumes: Timers one and three count outside, their values arrive here
// Notes: Avalon-MM slave with one wait state on every access
//
// Design decisions made here: the address map and register access over Avalon-MM.

module ecpwm_core #(
  parameter int TMR_W = 16 // Width of timers one and three
) (
  // Clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  // Avalon-MM slave
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Time bases and capture pin
  input wire logic [TMR_W-1:0] i_timer_one_pair_value,
  input wire logic [TMR_W-1:0] i_timer_three_pair_value,
  input wire logic i_capture_pin,
  // Special event and unit flag
  output logic o_timer_one_pair_reset,
  output logic o_timer_three_pair_reset,
  output logic o_adc_start,
  output logic o_flag,
  // Output pins, enable high when the unit drives the pin
  output logic o_out_a,
  output logic o_out_b,
  output logic o_out_c,
  output logic o_out_d,
  output logic o_en_a,
  output logic o_en_b,
  output logic o_en_c,
  output logic o_en_d
);
  // ---------------------------------------------------------------
  // Elaboration check
  // ---------------------------------------------------------------
  if (TMR_W < 2 || TMR_W > 16) begin : g_bad_width
    $error("TMR_W must lie in 2..16");
  end

  // ---------------------------------------------------------------
  // Registers and bus
  // ---------------------------------------------------------------
  logic [7:0] ctrl_q; // Mode control
  logic [7:0] duty_buf_q; // Duty buffer
  logic [7:0] period_q; // Period register
  logic [6:0] db_cfg_q; // Dead-band delay in instruction cycles
  logic [TMR_W-1:0] cmp_q; // Compare value
  logic [TMR_W-1:0] cap_q; // Captured value
  logic [2:0] tctrl_q; // Prescale select and timer select
  logic flag_q; // Sticky unit interrupt flag
  logic ack_q; // Access answered this cycle
  logic req; // Access pending
  logic wr_go; // Write takes effect
  logic ctrl_wr; // Mode control written
  logic [3:0] mode;
  logic pwm_mode;
  logic [TMR_W-1:0] tbase;

  assign req = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~ack_q;
  // A write lands only at the edge where the master sees waitrequest low
  assign wr_go = i_ce & i_avs_write & ack_q & (i_avs_address == ecpwm_pkg::ADDR_MODE_CTRL
    | i_avs_address == ecpwm_pkg::ADDR_DUTY_BUF | i_avs_address == ecpwm_pkg::ADDR_PERIOD
    | i_avs_address == ecpwm_pkg::ADDR_DEADBAND | i_avs_address == ecpwm_pkg::ADDR_COMPARE
    | i_avs_address == ecpwm_pkg::ADDR_STATUS | i_avs_address == ecpwm_pkg::ADDR_TIMER_CTRL);
  assign ctrl_wr = wr_go & i_avs_byteenable[0] & (i_avs_address == ecpwm_pkg::ADDR_MODE_CTRL);
  assign mode = ctrl_q[3:0];
  assign pwm_mode = (ctrl_q[3:2] == ecpwm_pkg::MODE_HI_PWM);
  // Capture and compare run on timer one or three
  assign tbase = tctrl_q[ecpwm_pkg::TCTRL_SEL_BIT] ? i_timer_three_pair_value : i_timer_one_pair_value;

  // One wait state, then the answer
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ack_q <= 1'b0;
    end else if (i_ce) begin
      ack_q <= req & ~ack_q;
    end
  end

  // Software-written registers, byte lane 0 (lane 1 for compare high byte)
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q <= ecpwm_pkg::MODE_CTRL_RESET;
      duty_buf_q <= 8'h00;
      period_q <= 8'h00;
      db_cfg_q <= 7'h00;
      cmp_q <= '0;
      tctrl_q <= 3'h0;
    end else if (wr_go) begin
      unique case (i_avs_address)
        ecpwm_pkg::ADDR_MODE_CTRL: if (i_avs_byteenable[0]) ctrl_q <= i_avs_writedata[7:0];
        ecpwm_pkg::ADDR_DUTY_BUF: if (i_avs_byteenable[0]) duty_buf_q <= i_avs_writedata[7:0];
        ecpwm_pkg::ADDR_PERIOD: if (i_avs_byteenable[0]) period_q <= i_avs_writedata[7:0];
        ecpwm_pkg::ADDR_DEADBAND: if (i_avs_byteenable[0]) db_cfg_q <= i_avs_writedata[6:0];
        ecpwm_pkg::ADDR_COMPARE: begin
          for (int i = 0; i < TMR_W; i++) begin
            if (i_avs_byteenable[i/8]) cmp_q[i] <= i_avs_writedata[i];
          end
        end
        ecpwm_pkg::ADDR_TIMER_CTRL: if (i_avs_byteenable[0]) tctrl_q <= i_avs_writedata[2:0];
        default: ; // Status writes handled with the flag
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Capture input: two-stage synchroniser, then edges
  // ---------------------------------------------------------------
  logic cap_meta_q;
  logic cap_sync_q;
  logic cap_prev_q;
  logic [3:0] cap_div_q; // Rising edges seen since mode entry
  logic cap_rise;
  logic cap_fall;
  logic cap_event;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cap_meta_q <= 1'b0;
      cap_sync_q <= 1'b0;
      cap_prev_q <= 1'b0;
    end else if (i_ce) begin
      cap_meta_q <= i_capture_pin;
      cap_sync_q <= cap_meta_q;
      cap_prev_q <= cap_sync_q;
    end
  end

  assign cap_rise = cap_sync_q & ~cap_prev_q;
  assign cap_fall = ~cap_sync_q & cap_prev_q;

  // Edge selection per capture mode
  always_comb begin
    unique case (mode)
      ecpwm_pkg::MODE_CAP_FALL: cap_event = cap_fall;
      ecpwm_pkg::MODE_CAP_RISE: cap_event = cap_rise;
      ecpwm_pkg::MODE_CAP_RISE4: cap_event = cap_rise
        & (cap_div_q[1:0] == ecpwm_pkg::CAP_DIV4_LAST[1:0]);
      ecpwm_pkg::MODE_CAP_RISE16: cap_event = cap_rise & (cap_div_q == ecpwm_pkg::CAP_DIV16_LAST);
      default: cap_event = 1'b0;
    endcase
  end

  // Edge divider restarts on every mode write so the count is clean
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cap_div_q <= 4'h0;
      cap_q <= '0;
    end else if (i_ce) begin
      if (ctrl_wr) begin
        cap_div_q <= 4'h0;
      end else if (cap_rise) begin
        cap_div_q <= cap_div_q + 4'h1;
      end
      if (mode == ecpwm_pkg::MODE_OFF) begin
        cap_q <= '0;
      end else if (cap_event) begin
        cap_q <= tbase;
      end
    end
  end

  // ---------------------------------------------------------------
  // Compare and special event
  // ---------------------------------------------------------------
  logic match_q; // Match seen last cycle, one event per match
  logic match_rise;
  logic cmp_mode;
  logic cmp_pin_q; // Compare output level
  logic flag_set;

  assign cmp_mode = (mode == ecpwm_pkg::MODE_CMP_TOGGLE) | (mode[3:2] == 2'b10);
  assign match_rise = cmp_mode & (cmp_q == tbase) & ~match_q;
  assign flag_set = match_rise | cap_event;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      match_q <= 1'b0;
      cmp_pin_q <= 1'b0;
    end else if (i_ce) begin
      match_q <= cmp_mode & (cmp_q == tbase);
      if (ctrl_wr) begin
        // Initial pin level taken on entry to a compare mode
        cmp_pin_q <= (i_avs_writedata[3:0] == ecpwm_pkg::MODE_CMP_CLR);
      end else if (match_rise) begin
        unique case (mode)
          ecpwm_pkg::MODE_CMP_TOGGLE: cmp_pin_q <= ~cmp_pin_q;
          ecpwm_pkg::MODE_CMP_SET: cmp_pin_q <= 1'b1;
          ecpwm_pkg::MODE_CMP_CLR: cmp_pin_q <= 1'b0;
          default: ; // Software-only and special event leave the pin alone
        endcase
      end
    end
  end

  // Special event pulses; the converter must already be enabled by software
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_timer_one_pair_reset <= 1'b0;
      o_timer_three_pair_reset <= 1'b0;
      o_adc_start <= 1'b0;
    end else if (i_ce) begin
      o_timer_one_pair_reset <= match_rise & (mode == ecpwm_pkg::MODE_CMP_SPECIAL)
        & ~tctrl_q[ecpwm_pkg::TCTRL_SEL_BIT];
      o_timer_three_pair_reset <= match_rise & (mode == ecpwm_pkg::MODE_CMP_SPECIAL)
        & tctrl_q[ecpwm_pkg::TCTRL_SEL_BIT];
      o_adc_start <= match_rise & (mode == ecpwm_pkg::MODE_CMP_SPECIAL);
    end
  end

  // Sticky flag, write one to clear; a new event beats the clear
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      flag_q <= 1'b0;
    end else if (i_ce) begin
      if (flag_set) begin
        flag_q <= 1'b1;
      end else if (wr_go & i_avs_byteenable[0] & (i_avs_address == ecpwm_pkg::ADDR_STATUS)
          & i_avs_writedata[ecpwm_pkg::STAT_FLAG_BIT]) begin
        flag_q <= 1'b0;
      end
    end
  end
  assign o_flag = flag_q;

  // ---------------------------------------------------------------
  // Period timer with prescaler; postscaler is not part of this path
  // ---------------------------------------------------------------
  logic [5:0] pre_cnt_q; // Oscillator periods within one timer tick
  logic [7:0] tmr_q; // Period timer
  logic [5:0] pre_lim;
  logic [1:0] low2; // Quarter-cycle or prescaler bits
  logic tick;
  logic boundary;

  always_comb begin
    unique case (tctrl_q[1:0])
      2'b00: begin
        pre_lim = ecpwm_pkg::PRE_LIM_1;
        low2 = pre_cnt_q[1:0];
      end
      2'b01: begin
        pre_lim = ecpwm_pkg::PRE_LIM_4;
        low2 = pre_cnt_q[3:2];
      end
      default: begin
        pre_lim = ecpwm_pkg::PRE_LIM_16;
        low2 = pre_cnt_q[5:4];
      end
    endcase
  end

  assign tick = (pre_cnt_q == pre_lim);
  assign boundary = pwm_mode & tick & (tmr_q == period_q);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pre_cnt_q <= 6'h00;
      tmr_q <= 8'h00;
    end else if (i_ce) begin
      if (!pwm_mode) begin
        pre_cnt_q <= 6'h00;
        tmr_q <= 8'h00;
      end else begin
        pre_cnt_q <= tick ? 6'h00 : pre_cnt_q + 6'h01;
        if (boundary) begin
          tmr_q <= 8'h00;
        end else if (tick) begin
          tmr_q <= tmr_q + 8'h01;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // PWM core with double-buffered settings
  // ---------------------------------------------------------------
  logic run_q; // Running after first period boundary
  logic [9:0] duty_act_q; // Active ten-bit duty
  logic [1:0] cfg_act_q; // Active output configuration
  logic [1:0] pol_act_q; // Active polarity, bit 1 for A/C, bit 0 for B/D
  logic [6:0] db_act_q; // Active dead-band delay
  logic [6:0] db_cnt_q; // Remaining dead time
  logic lvl_q; // Modulated level, active high
  logic lvl_prev_q;
  logic lvl; // Modulated level seen by the pins
  logic [9:0] duty_next;
  logic duty_hit;

  assign duty_next = {duty_buf_q, ctrl_q[5:4]};
  assign duty_hit = run_q & ({tmr_q, low2} == duty_act_q);
  // Level drops in the very cycle the count reaches the duty value
  assign lvl = lvl_q & ~duty_hit;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      run_q <= 1'b0;
      duty_act_q <= 10'h000;
      cfg_act_q <= 2'h0;
      pol_act_q <= 2'h0;
      lvl_q <= 1'b0;
    end else if (i_ce) begin
      if (!pwm_mode) begin
        run_q <= 1'b0;
        lvl_q <= 1'b0;
      end else if (boundary) begin
        run_q <= 1'b1;
        duty_act_q <= duty_next;
        cfg_act_q <= ctrl_q[7:6];
        pol_act_q <= ctrl_q[1:0];
        lvl_q <= (duty_next != 10'h000);
      end else if (duty_hit) begin
        lvl_q <= 1'b0;
      end
    end
  end

  // Dead time counted in instruction cycles after each level change
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      db_act_q <= 7'h00;
      db_cnt_q <= 7'h00;
      lvl_prev_q <= 1'b0;
    end else if (i_ce) begin
      lvl_prev_q <= lvl;
      if (boundary | duty_hit) begin
        db_act_q <= db_cfg_q;
      end
      if (lvl != lvl_prev_q) begin
        db_cnt_q <= db_act_q;
      end else if (db_cnt_q != 7'h00 && pre_cnt_q[1:0] == 2'(ecpwm_pkg::OSC_PER_INSTR - 1)) begin
        db_cnt_q <= db_cnt_q - 7'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // Output steering: logical active levels, then polarity
  // ---------------------------------------------------------------
  logic [3:0] act_d; // Active levels A..D, bit 0 is A
  logic [3:0] en_d;
  logic dead;

  // Dead time also covers the change cycle itself, so neither half-bridge output turns on early
  assign dead = (db_cnt_q != 7'h00) | ((lvl != lvl_prev_q) & (db_act_q != 7'h00));

  always_comb begin
    act_d = 4'h0;
    en_d = 4'h0;
    if (pwm_mode && run_q) begin
      unique case (ecpwm_pkg::ecpwm_cfg_type'(cfg_act_q))
        ecpwm_pkg::ECPWM_CFG_SINGLE: begin
          act_d = {3'b000, lvl};
          en_d = 4'b0001;
        end
        ecpwm_pkg::ECPWM_CFG_FWD: begin
          act_d = {lvl, 2'b00, 1'b1};
          en_d = 4'b1111;
        end
        ecpwm_pkg::ECPWM_CFG_HALF: begin
          act_d = {2'b00, ~lvl & ~dead, lvl & ~dead};
          en_d = 4'b0011;
        end
        ecpwm_pkg::ECPWM_CFG_REV: begin
          act_d = {2'b01, lvl, 1'b0};
          en_d = 4'b1111;
        end
      endcase
    end else if (pwm_mode) begin
      // Waiting for first boundary: pin A driven inactive, pins B-D left to the port
      en_d = 4'b0001;
    end else if (cmp_mode && mode != ecpwm_pkg::MODE_CMP_SOFT) begin
      act_d = {3'b000, cmp_pin_q};
      en_d = 4'b0001;
    end
    // Off, reserved and capture modes leave every pin to the port
  end

  // Registered pins with pair polarity
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_out_a <= 1'b0;
      o_out_b <= 1'b0;
      o_out_c <= 1'b0;
      o_out_d <= 1'b0;
      o_en_a <= 1'b0;
      o_en_b <= 1'b0;
      o_en_c <= 1'b0;
      o_en_d <= 1'b0;
    end else if (i_ce) begin
      o_out_a <= act_d[0] ^ (pwm_mode & pol_act_q[1]);
      o_out_b <= act_d[1] ^ (pwm_mode & pol_act_q[0]);
      o_out_c <= act_d[2] ^ (pwm_mode & pol_act_q[1]);
      o_out_d <= act_d[3] ^ (pwm_mode & pol_act_q[0]);
      o_en_a <= en_d[0];
      o_en_b <= en_d[1];
      o_en_c <= en_d[2];
      o_en_d <= en_d[3];
    end
  end

  // ---------------------------------------------------------------
  // Read data, registered in the wait state for the answer
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_ce && i_avs_read && !ack_q) begin
      o_avs_readdata <= 32'h0000_0000; // Unmapped reads as zero
      unique case (i_avs_address)
        ecpwm_pkg::ADDR_MODE_CTRL: o_avs_readdata[7:0] <= ctrl_q;
        ecpwm_pkg::ADDR_DUTY_BUF: o_avs_readdata[7:0] <= duty_buf_q;
        ecpwm_pkg::ADDR_PERIOD: o_avs_readdata[7:0] <= period_q;
        ecpwm_pkg::ADDR_DEADBAND: o_avs_readdata[6:0] <= db_cfg_q;
        ecpwm_pkg::ADDR_COMPARE: o_avs_readdata[TMR_W-1:0] <= cmp_q;
        ecpwm_pkg::ADDR_CAPTURE: o_avs_readdata[TMR_W-1:0] <= cap_q;
        ecpwm_pkg::ADDR_STATUS: begin
          o_avs_readdata[ecpwm_pkg::STAT_FLAG_BIT] <= flag_q;
          o_avs_readdata[ecpwm_pkg::STAT_RUN_BIT] <= run_q;
          o_avs_readdata[ecpwm_pkg::STAT_TIMER_LSB +: 8] <= tmr_q;
        end
        ecpwm_pkg::ADDR_TIMER_CTRL: o_avs_readdata[2:0] <= tctrl_q;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_special_match;
    i_ce && mode == ecpwm_pkg::MODE_CMP_SPECIAL && match_rise;
  endsequence
  sequence s_boundary;
    i_ce && boundary;
  endsequence

  property p_port_release;
    @(posedge i_clk_sys) disable iff (i_rst)
      i_ce && !pwm_mode && !cmp_mode |=> !o_en_a && !o_en_b && !o_en_c && !o_en_d;
  endproperty
  a_port_release: assert property (p_port_release) else $error("pins not released");

  property p_single;
    @(posedge i_clk_sys) disable iff (i_rst)
      i_ce && pwm_mode && run_q && cfg_act_q == 2'b00 |=> !o_en_b && !o_en_c && !o_en_d;
  endproperty
  a_single: assert property (p_single) else $error("single output drives B-D");

  property p_forward;
    @(posedge i_clk_sys) disable iff (i_rst)
      i_ce && pwm_mode && run_q && cfg_act_q == 2'b01
      |=> o_out_a == !$past(pol_act_q[1]) && o_out_b == $past(pol_act_q[0]);
  endproperty
  a_forward: assert property (p_forward) else $error("forward levels wrong");

  property p_reverse;
    @(posedge i_clk_sys) disable iff (i_rst)
      i_ce && pwm_mode && run_q && cfg_act_q == 2'b11
      |=> o_out_c == !$past(pol_act_q[1]) && o_out_a == $past(pol_act_q[1]);
  endproperty
  a_reverse: assert property (p_reverse) else $error("reverse levels wrong");

  property p_duty_copy;
    s_boundary |=> duty_act_q == $past(duty_next) && tmr_q == 8'h00 && run_q;
  endproperty
  a_duty_copy: assert property (@(posedge i_clk_sys) disable iff (i_rst) p_duty_copy)
    else $error("boundary did not load duty");

  property p_zero_duty;
    @(posedge i_clk_sys) disable iff (i_rst)
      s_boundary ##0 duty_next == 10'h000 |=> !lvl_q;
  endproperty
  a_zero_duty: assert property (p_zero_duty) else $error("zero duty set output");

  property p_special;
    @(posedge i_clk_sys) disable iff (i_rst)
      s_special_match |=> o_adc_start && o_flag && (o_timer_one_pair_reset != o_timer_three_pair_reset);
  endproperty
  a_special: assert property (p_special) else $error("special event incomplete");

  property p_start_wait;
    @(posedge i_clk_sys) disable iff (i_rst)
      i_ce && !pwm_mode ##1 i_ce && pwm_mode && !boundary |=> !run_q;
  endproperty
  a_start_wait: assert property (p_start_wait) else $error("PWM ran before reset");
endmodule

// ==== inc/ecpwm_pkg.sv ====
// Purpose: Shared constants for the enhanced capture/compare/PWM unit
// Assumes: One system clock, each enabled cycle counts as one oscillator period
// Notes: Byte addresses on a 32-bit Avalon-MM slave, data in the low bits
package ecpwm_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_MODE_CTRL = 5'h00; // Mode control
  localparam logic [4:0] ADDR_DUTY_BUF = 5'h04; // Duty buffer, upper eight bits
  localparam logic [4:0] ADDR_PERIOD = 5'h08; // Period register
  localparam logic [4:0] ADDR_DEADBAND = 5'h0c; // Dead-band delay
  localparam logic [4:0] ADDR_COMPARE = 5'h10; // Compare value
  localparam logic [4:0] ADDR_CAPTURE = 5'h14; // Captured timer value
  localparam logic [4:0] ADDR_STATUS = 5'h18; // Flag, run state, period timer
  localparam logic [4:0] ADDR_TIMER_CTRL = 5'h1c; // Prescale and timer select
  localparam logic [7:0] MODE_CTRL_RESET = 8'h00; // Control reset value
  // Status fields
  localparam int STAT_FLAG_BIT = 0;
  localparam int STAT_RUN_BIT = 1;
  localparam int STAT_TIMER_LSB = 8;
  localparam int TCTRL_SEL_BIT = 2; // Timer three when set
  // ---------------------------------------------------------------
  // Mode select and output configuration codes
  // ---------------------------------------------------------------
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR = 4'h9;
  localparam logic [3:0] MODE_CMP_SOFT = 4'ha;
  localparam logic [3:0] MODE_CMP_SPECIAL = 4'hb;
  localparam logic [1:0] MODE_HI_PWM = 2'h3; // Upper two mode bits in PWM
  typedef enum logic [1:0] {
    ECPWM_CFG_SINGLE = 2'b00,
    ECPWM_CFG_FWD = 2'b01,
    ECPWM_CFG_HALF = 2'b10,
    ECPWM_CFG_REV = 2'b11
  } ecpwm_cfg_type;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int OSC_PER_INSTR = 4; // Oscillator periods per instruction cycle
  localparam logic [5:0] PRE_LIM_1 = 6'h03; // Prescale 1: 4 periods per tick
  localparam logic [5:0] PRE_LIM_4 = 6'h0f; // Prescale 4
  localparam logic [5:0] PRE_LIM_16 = 6'h3f; // Prescale 16
  localparam logic [3:0] CAP_DIV4_LAST = 4'h3;
  localparam logic [3:0] CAP_DIV16_LAST = 4'hf;
endpackage

// ==== tb/ecpwm_load.sv ====
// Purpose: Load model for the four bridge pins
// Assumes: Port logic pulls a released pin low
// Notes: Counts driven-high cycles on pins A and D
module ecpwm_load (
  // Clock
  input wire logic i_clk_sys,
  // Pins from the unit
  input wire logic [3:0] i_out,
  input wire logic [3:0] i_en,
  // High-time counters
  output int o_hi_a,
  output int o_hi_d
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] pin; // Resolved pin level
  // Released pin falls to the pull-down, never keeps its last value
  // Software has set the port directions, so enabled drive reaches the load
  assign pin = i_out & i_en;
  // A load integrates drive, so count high cycles
  always @(posedge i_clk_sys) begin
    o_hi_a <= o_hi_a + int'(pin[0]);
    o_hi_d <= o_hi_d + int'(pin[3]);
  end
endmodule

// ==== tb/enhanced_capture_compare_pwm_bench.sv ====
// Purpose: Self-checking bench for the capture/compare/PWM unit
// Assumes: One wait state per bus access, timer one driven here
// Notes: Short period register keeps PWM runs brief
module enhanced_capture_compare_pwm_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0;
  logic rst = 1;
  logic [4:0] adr = 5'h00;
  logic rd = 0;
  logic wr = 0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q; // Last read word
  logic [15:0] t1 = 16'h0000; // Timer one value
  logic [3:0] pout;
  logic [3:0] pen;
  logic wreq, fl, r1, r3, adc;
  logic cpin = 0; // Capture pin level
  int hi_a, hi_d, a0, d0;
  int bad_count = 0;
  int checked = 0;
  always #5 clk = ~clk;
  ecpwm_core u_dut (.i_clk_sys(clk), .i_rst(rst), .i_ce(1'b1), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_timer_one_pair_value(t1),
    .i_timer_three_pair_value(16'h0000), .i_capture_pin(cpin), .o_timer_one_pair_reset(r1), .o_timer_three_pair_reset(r3),
    .o_adc_start(adc), .o_flag(fl), .o_out_a(pout[0]), .o_out_b(pout[1]),
    .o_out_c(pout[2]), .o_out_d(pout[3]), .o_en_a(pen[0]), .o_en_b(pen[1]),
    .o_en_c(pen[2]), .o_en_d(pen[3]));
  ecpwm_load u_load (.i_clk_sys(clk), .i_out(pout), .i_en(pen), .o_hi_a(hi_a), .o_hi_d(hi_d));
  // Compare and count
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Avalon access, held until waitrequest is sampled low
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= ~w;
    wd <= d;
    // Only the watchdog ends a wait that never answers
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Mode 1001 with bridge bits set: pin starts high, match clears it
  task t_cmp;
    bus(1, ecpwm_pkg::ADDR_COMPARE, 32'h40);
    bus(1, ecpwm_pkg::ADDR_MODE_CTRL, 32'hc9);
    repeat (3) @(posedge clk);
    chk("init_a", pout[0], 1);
    chk("en_b", pen[1], 0);
    t1 <= 16'h0040;
    repeat (3) @(posedge clk);
    t1 <= 16'h0000;
    chk("clr_a", pout[0], 0);
    chk("flag", fl, 1);
    bus(1, ecpwm_pkg::ADDR_STATUS, 32'h1);
    @(posedge clk);
    chk("flag_clr", fl, 0);
  endtask
  // Special event: timer reset and converter start together
  task t_evt;
    int n;
    // Converter taken as enabled by software before the trigger
    bus(1, ecpwm_pkg::ADDR_MODE_CTRL, 32'h0b);
    t1 <= 16'h0040;
    for (n = 0; n < 10 && adc !== 1'b1; n++) @(posedge clk);
    t1 <= 16'h0000;
    chk("adc", adc, 1);
    chk("t1rst", r1, 1);
    chk("flag2", fl, 1);
    chk("t3rst", r3, 0);
  endtask
  // Capture on a rising pin edge, timer one held steady around it
  task t_cap;
    bus(1, ecpwm_pkg::ADDR_MODE_CTRL, 32'h05);
    t1 <= 16'h1234;
    cpin <= 1'b1;
    repeat (6) @(posedge clk);
    cpin <= 1'b0;
    t1 <= 16'h0000;
    bus(0, ecpwm_pkg::ADDR_CAPTURE, 32'h0);
    chk("capture", q, 32'h1234);
  endtask
  // Forward bridge, period 16 cycles, duty 4 cycles
  task t_pwm;
    bus(1, ecpwm_pkg::ADDR_PERIOD, 32'h3);
    bus(1, ecpwm_pkg::ADDR_DUTY_BUF, 32'h1);
    bus(1, ecpwm_pkg::ADDR_TIMER_CTRL, 32'h0);
    bus(1, ecpwm_pkg::ADDR_MODE_CTRL, 32'h4c);
    repeat (60) @(posedge clk);
    chk("b_off", {pen[1], pout[1]}, 2'b10);
    a0 = hi_a;
    d0 = hi_d;
    repeat (32) @(posedge clk);
    chk("hi_a", hi_a - a0, 32);
    chk("hi_d", hi_d - d0, 8);
    bus(1, ecpwm_pkg::ADDR_MODE_CTRL, 32'h4e);
    repeat (60) @(posedge clk);
    chk("a_low", pout[0], 0);
    // Reverse bridge: A and D idle, C held active
    bus(1, ecpwm_pkg::ADDR_MODE_CTRL, 32'hcc);
    repeat (60) @(posedge clk);
    a0 = hi_a;
    d0 = hi_d;
    repeat (32) @(posedge clk);
    chk("rev_a", hi_a - a0, 0);
    chk("rev_d", hi_d - d0, 0);
    chk("rev_c", pout[2], 1);
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    bus(0, ecpwm_pkg::ADDR_MODE_CTRL, 32'h0);
    chk("mode_rst", q, 32'h0);
    bus(0, 5'h01, 32'h0);
    chk("unmapped", q, 32'h0);
    t_cmp;
    t_evt;
    t_cap;
    t_pwm;
    print_verdict;
  end
  // Whole run needs well under 1000 cycles
  initial begin
    #100us;
    bad_count++;
    print_verdict;
  end
endmodule
